/* hdl/vspg_pkg.sv */
// Constants for the virtual switch port-good pin block
package vspg_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [11:0] OFF_DIR_LO = 12'ha34;
  localparam logic [11:0] OFF_DIR_HI = 12'ha38;
  localparam logic [11:0] OFF_DBNC = 12'ha40;
  localparam logic [11:0] OFF_IN = 12'ha44;
  localparam logic [11:0] OFF_OUT = 12'ha48;
  localparam logic [11:0] OFF_VS_CFG = 12'ha60;
  // ==========================================================
  // Field layout
  localparam int PINS = 12;
  localparam int DIR_LO_PINS = 10;
  localparam int DIR_STRIDE = 3;
  localparam int DIR_FIRST = 2;
  localparam int TOP_PIN = 11;
  localparam int VS_CNT_W = 3;
  localparam logic [2:0] VS_CNT_MIN = 3'h4;
  localparam logic [2:0] VS_CNT_MAX = 3'h6;
  // ==========================================================
  // Reset values
  localparam logic [11:0] RST_PINS = 12'h000;
  localparam logic [2:0] RST_VS_CNT = 3'h1;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int DBNC_TIME_US = 1300;
  localparam int DBNC_CYCLES = DBNC_TIME_US * CLK_MHZ;
endpackage

/* hdl/vspg_pin_if.sv */
// Per-pin link between register logic and input filter
`timescale 1ns/1ps
interface vspg_pin_if;
  logic sample;
  logic filter_en;
  logic level;
  modport ctrl (output sample, output filter_en, input level);
  modport filt (input sample, input filter_en, output level);
endinterface

/* hdl/vspg_debounce.sv */
// Single-pin input filter with stability counter
`timescale 1ns/1ps
module vspg_debounce #(
  parameter int STABLE_CYCLES = 65000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Pin link
  vspg_pin_if.filt pin
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

  if (STABLE_CYCLES < 1) begin : g_bad_cycles
    $error("vspg_debounce: STABLE_CYCLES must be at least 1");
  end

  logic [CW-1:0] count;
  logic level;

  assign pin.level = level;

  // ==========================================================
  // Stability counter
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= '0;
    end else if (!pin.filter_en || pin.sample == level) begin
      count <= '0;
    end else if (count != LAST) begin
      count <= count + 1'b1;
    end
  end

  // ==========================================================
  // Accepted level
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      level <= 1'b0;
    end else if (!pin.filter_en) begin
      level <= pin.sample;
    end else if (pin.sample != level && count == LAST) begin
      level <= pin.sample;
    end
  end
endmodule

/* hdl/vspg_top.sv */
// Virtual switch port-good pins: filter, input and output data
`timescale 1ns/1ps
module vspg_top
  import vspg_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DBNC_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Link health pins
  input wire logic [PINS-1:0] i_link_health_pin,
  output logic [PINS-1:0] o_link_health_pin,
  output logic [PINS-1:0] o_link_health_pin_oe
);
  // ==========================================================
  // Elaboration checks
  if (DEBOUNCE_CYCLES < 1) begin : g_bad_cycles
    $error("vspg_top: DEBOUNCE_CYCLES must be at least 1");
  end
  if (PINS > 32 || TOP_PIN != PINS - 1) begin : g_bad_pins
    $error("vspg_top: pin count does not fit the registers");
  end
  if (DIR_LO_PINS >= PINS) begin : g_bad_split
    $error("vspg_top: pins must span both direction words");
  end
  if (DIR_STRIDE*(DIR_LO_PINS-1)+DIR_FIRST > 31) begin : g_bad_lo
    $error("vspg_top: low direction field out of range");
  end
  if (DIR_STRIDE*(PINS-DIR_LO_PINS-1)+DIR_FIRST > 31) begin : g_bad_hi
    $error("vspg_top: high direction field out of range");
  end
  if (int'(VS_CNT_MAX) >= (1 << VS_CNT_W)) begin : g_bad_cnt
    $error("vspg_top: switch count field too narrow");
  end
  if (VS_CNT_MIN > VS_CNT_MAX) begin : g_bad_range
    $error("vspg_top: switch count range is empty");
  end

  // Stored registers and the bit 11 mask derived from the switch count
  logic [PINS-1:0] dir;
  logic [PINS-1:0] dbnc;
  logic [PINS-1:0] out_data;
  logic [VS_CNT_W-1:0] vs_cnt;
  logic [PINS-1:0] mask;

  // Input path
  logic [PINS-1:0] sync1;
  logic [PINS-1:0] sync2;
  logic [PINS-1:0] sync3;
  logic [PINS-1:0] agree;
  logic [PINS-1:0] stable;
  logic [PINS-1:0] level;
  logic [PINS-1:0] in_view;

  // Next values
  logic [PINS-1:0] next_dir;
  logic [PINS-1:0] next_dbnc;
  logic [PINS-1:0] next_out;
  logic [VS_CNT_W-1:0] next_vs_cnt;
  logic [PINS-1:0] next_mask;

  // Write strobes
  logic wr_dir_lo;
  logic wr_dir_hi;
  logic wr_dbnc;
  logic wr_out;
  logic wr_vs_cfg;

  // Read path
  logic [31:0] dir_lo_word;
  logic [31:0] dir_hi_word;
  logic [31:0] next_rdata;

  // ==========================================================
  // Bit 11 availability
  function automatic logic [PINS-1:0] pin_mask(logic [VS_CNT_W-1:0] n);
    logic [PINS-1:0] m;
    m = '1;
    m[TOP_PIN] = (n >= VS_CNT_MIN) && (n <= VS_CNT_MAX);
    return m;
  endfunction

  assign mask = pin_mask(vs_cnt);

  // ==========================================================
  // Direction field placement
  always_comb begin
    dir_lo_word = '0;
    dir_hi_word = '0;
    for (int n = 0; n < DIR_LO_PINS; n++) begin
      dir_lo_word[DIR_STRIDE*n+DIR_FIRST] = dir[n];
    end
    for (int n = DIR_LO_PINS; n < PINS; n++) begin
      dir_hi_word[DIR_STRIDE*(n-DIR_LO_PINS)+DIR_FIRST] = dir[n];
    end
  end

  // ==========================================================
  // Write strobes per register
  assign wr_dir_lo = i_wr && (i_addr == OFF_DIR_LO);
  assign wr_dir_hi = i_wr && (i_addr == OFF_DIR_HI);
  assign wr_dbnc = i_wr && (i_addr == OFF_DBNC);
  assign wr_out = i_wr && (i_addr == OFF_OUT);
  assign wr_vs_cfg = i_wr && (i_addr == OFF_VS_CFG);

  // ==========================================================
  // Next switch count and bit 11 availability
  always_comb begin
    next_vs_cnt = vs_cnt;
    if (wr_vs_cfg) begin
      next_vs_cnt = i_wdata[VS_CNT_W-1:0];
    end
    next_mask = pin_mask(next_vs_cnt);
  end

  // ==========================================================
  // Next direction
  always_comb begin
    next_dir = dir;
    if (wr_dir_lo) begin
      for (int n = 0; n < DIR_LO_PINS; n++) begin
        next_dir[n] = i_wdata[DIR_STRIDE*n+DIR_FIRST];
      end
    end
    if (wr_dir_hi) begin
      for (int n = DIR_LO_PINS; n < PINS; n++) begin
        next_dir[n] = i_wdata[DIR_STRIDE*(n-DIR_LO_PINS)+DIR_FIRST];
      end
    end
    next_dir = next_dir & next_mask;
  end

  // ==========================================================
  // Next de-bounce enables
  always_comb begin
    next_dbnc = dbnc;
    if (wr_dbnc) begin
      next_dbnc = i_wdata[PINS-1:0];
    end
    next_dbnc = next_dbnc & next_mask;
  end

  // ==========================================================
  // Next output data
  always_comb begin
    next_out = out_data;
    if (wr_out) begin
      next_out = i_wdata[PINS-1:0];
    end
    next_out = next_out & next_mask;
  end

  // ==========================================================
  // Direction register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dir <= RST_PINS;
    end else begin
      dir <= next_dir;
    end
  end

  // ==========================================================
  // De-bounce enable register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dbnc <= RST_PINS;
    end else begin
      dbnc <= next_dbnc;
    end
  end

  // ==========================================================
  // Output data register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_data <= RST_PINS;
    end else begin
      out_data <= next_out;
    end
  end

  // ==========================================================
  // Switch count register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vs_cnt <= RST_VS_CNT;
    end else begin
      vs_cnt <= next_vs_cnt;
    end
  end

  // ==========================================================
  // Pin drive, same edge as the write
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_link_health_pin <= RST_PINS;
    end else begin
      o_link_health_pin <= next_out & next_dir;
    end
  end

  // ==========================================================
  // Pin output enable
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_link_health_pin_oe <= RST_PINS;
    end else begin
      o_link_health_pin_oe <= next_dir;
    end
  end

  // ==========================================================
  // Pin input synchroniser
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= i_link_health_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ==========================================================
  // Second and third stage agree
  assign agree = ~(sync2 ^ sync3);

  // ==========================================================
  // Agreed pin level
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stable <= '0;
    end else begin
      for (int n = 0; n < PINS; n++) begin
        if (agree[n]) begin
          stable[n] <= sync3[n];
        end
      end
    end
  end

  // ==========================================================
  // Per-pin filters
  generate
    for (genvar g = 0; g < PINS; g++) begin : g_pin
      vspg_pin_if link ();
      assign link.sample = stable[g];
      assign link.filter_en = dbnc[g] & ~dir[g];
      assign level[g] = link.level;
      vspg_debounce #(
        .STABLE_CYCLES(DEBOUNCE_CYCLES)
      ) u_filt (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .pin(link.filt)
      );
    end
  endgenerate

  // ==========================================================
  // Input data view: output pins read 0, bit 11 reads 0 unless the switch count is 4 to 6
  assign in_view = level & ~dir & mask;

  // ==========================================================
  // Register read mux, unmapped offsets read 0
  always_comb begin
    next_rdata = '0;
    unique case (i_addr)
      OFF_DIR_LO: next_rdata = dir_lo_word;
      OFF_DIR_HI: next_rdata = dir_hi_word;
      OFF_DBNC: next_rdata[PINS-1:0] = dbnc;
      OFF_IN: next_rdata[PINS-1:0] = in_view;
      OFF_OUT: next_rdata[PINS-1:0] = out_data;
      OFF_VS_CFG: next_rdata[VS_CNT_W-1:0] = vs_cnt;
      default: next_rdata = '0;
    endcase
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= '0;
    end
  end
endmodule

/* verification/vspg_monitor.sv */
// Checker for the port-good pin block
`timescale 1ns/1ps
module vspg_monitor
  import vspg_pkg::*;
#(parameter int DEBOUNCE_CYCLES = DBNC_CYCLES) (
  // Bus
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Pins
  input wire logic [PINS-1:0] o_link_health_pin,
  input wire logic [PINS-1:0] o_link_health_pin_oe
);
  // ==========
  // Properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire logic wo = i_wr && i_addr == OFF_OUT;
  wire logic ri = i_rd && i_addr == OFF_IN;
  idle_zero_a: assert property (!i_rd |=> o_rdata == 0)
    else $error("rdata not idle");
  rsvd_zero_a: assert property (i_rd && i_addr[11:4] == 8'ha4 |=>
    o_rdata[31:12] == 0) else $error("reserved bits");
  map_zero_a: assert property (i_rd && i_addr[11:8] != 4'ha |=>
    o_rdata == 0) else $error("unmapped read");
  drive_gate_a: assert property ((o_link_health_pin &
    ~o_link_health_pin_oe) == 0) else $error("drive without enable");
  in_zero_a: assert property (ri && !$past(i_wr) |=>
    (o_rdata[11:0] & $past(o_link_health_pin_oe)) == 0) else $error("in");
  out_drive_a: assert property (wo |=> ((o_link_health_pin ^
    $past(i_wdata[11:0])) & o_link_health_pin_oe & 12'h7ff) == 0)
    else $error("pin not driven");
  oe_hold_a: assert property (!i_wr |=> $stable(o_link_health_pin_oe))
    else $error("direction moved");
  pin_hold_a: assert property (!i_wr |=> $stable(o_link_health_pin))
    else $error("pin moved");
  cover property (wo ##1 o_link_health_pin != 0);
  cover property (ri ##1 o_rdata != 0);
  cover property (i_rd && i_addr[11:8] != 4'ha);
endmodule
bind vspg_top vspg_monitor #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_mon (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_link_health_pin(o_link_health_pin),
  .o_link_health_pin_oe(o_link_health_pin_oe));

/* verification/vspg_board.sv */
// Board-side model of the link health pins
`timescale 1ns/1ps
module vspg_board (
  // Bench level
  input wire logic [11:0] i_level,
  // Device pins
  input wire logic [11:0] i_drive,
  input wire logic [11:0] i_drive_oe,
  output logic [11:0] o_pin
);
  // ==========
  // Board drives only pins the device leaves as inputs
  assign o_pin = (i_drive & i_drive_oe) | (i_level & ~i_drive_oe);
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the port-good pin block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  import vspg_pkg::*;
  // ==========
  // Signals
  logic clk = 0, rstn = 0, wr = 0, rd = 0;
  logic [11:0] addr = 0, lvl = 0, v = 0, pin_in, pin_out, pin_oe;
  logic [31:0] wdata = 0, rdata, d;
  int miscompares = 0, compares = 0;
  vspg_top #(.DEBOUNCE_CYCLES(8)) i_dut (.i_clk(clk), .i_resetn(rstn),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_link_health_pin(pin_in), .o_link_health_pin(pin_out),
    .o_link_health_pin_oe(pin_oe));
  vspg_board i_board (.i_level(lvl), .i_drive(pin_out), .i_drive_oe(pin_oe),
    .o_pin(pin_in));
  // ==========
  // Bus tasks
  task automatic wreg(input logic [11:0] a, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    #1;
  endtask
  task automatic rreg(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 d = rdata;
  endtask
  task automatic setdir(input logic [11:0] m);
    logic [31:0] lo;
    lo = 0;
    for (int n = 0; n < 10; n++) lo[3 * n + 2] = m[n];
    wreg(OFF_DIR_LO, lo);
    wreg(OFF_DIR_HI, {26'h0, m[11], 2'h0, m[10], 2'h0});
  endtask
  function automatic logic [31:0] ev(input logic [11:0] x);
    ev = {20'h0, x & 12'h7ff};
  endfunction
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========
  // Scenarios
  initial forever #10 clk = ~clk;
  initial begin
    void'($urandom(26));
    repeat (2) @(posedge clk);
    rstn <= 1;
    for (int i = 0; i < 4; i++) begin
      rreg(i < 3 ? OFF_DBNC + 12'(4 * i) : 12'h150);
      `CHK("reset", 32'h0, d)
    end
    setdir(12'hfff);
    `CHK("oe", 12'h7ff, pin_oe)
    repeat (4) begin
      v = 12'($urandom);
      wreg(OFF_OUT, {20'h0, v});
      `CHK("pin", v & 12'h7ff, pin_out)
      rreg(OFF_IN);
      `CHK("in", 32'h0, d)
    end
    for (int k = 0; k < 11; k++) begin
      setdir(12'(1 << k));
      `CHK("dir", 12'(1 << k), pin_oe)
    end
    setdir(12'h0);
    repeat (4) begin
      @(posedge clk);
      lvl <= 12'($urandom);
      wreg(OFF_IN, 32'hffffffff);
      repeat (8) @(posedge clk);
      rreg(OFF_IN);
      `CHK("level", ev(lvl), d)
      rreg(OFF_OUT);
      `CHK("out", ev(v), d)
      `CHK("idle", 12'h0, pin_out)
    end
    wreg(OFF_DBNC, 32'hfff);
    @(posedge clk);
    lvl <= ~lvl;
    repeat (5) @(posedge clk);
    rreg(OFF_IN);
    `CHK("hold", ev(~lvl), d)
    repeat (16) @(posedge clk);
    rreg(OFF_IN);
    `CHK("filt", ev(lvl), d)
    rstn <= 0;
    @(posedge clk);
    rstn <= 1;
    rreg(OFF_OUT);
    `CHK("rst out", 32'h0, d)
    rreg(OFF_DBNC);
    `CHK("rst dbnc", 32'h0, d)
    wreg(OFF_VS_CFG, 32'h4);
    setdir(12'h800);
    wreg(OFF_OUT, 32'h800);
    `CHK("top", 12'h800, pin_out)
    wreg(OFF_VS_CFG, 32'h1);
    rreg(OFF_OUT);
    `CHK("top off", 32'h0, d)
    print_verdict();
  end
endmodule
